// *** rtl/mtm_pkg.sv ***
package mtm_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_STAT_CTRL = 5'h00;
    localparam logic [4:0] OFS_CLK_CFG   = 5'h04;
    localparam logic [4:0] OFS_COUNT     = 5'h08;
    localparam logic [4:0] OFS_MODULO    = 5'h0c;
    localparam logic [4:0] OFS_IRQ_STAT  = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK  = 5'h14;

    // status and control bit positions
    localparam int STC_OVF_BIT    = 7;
    localparam int STC_IRQ_EN_BIT = 6;
    localparam int STC_RST_BIT    = 5;
    localparam int STC_HALT_BIT   = 4;

    // clock configuration field positions
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_PS_LSB  = 0;

    // interrupt status and mask bit position
    localparam int IRQ_OVF_BIT = 0;

    // values after reset
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] MODULO_RST = 8'h00;
    localparam logic       HALT_RST   = 1'b1;
    localparam logic       IRQ_EN_RST = 1'b0;
    localparam logic [2:0] PS_RST     = 3'h0;

    // modulo of zero selects the full 8-bit range
    localparam logic [7:0] ZERO_MODULO = 8'h00;
    localparam logic [7:0] FULL_RANGE  = 8'hff;

    // top prescale code divides by 256, others by two to the code
    localparam logic [2:0] PS_SEL_TOP  = 3'h7;
    localparam logic [7:0] PS_TERM_TOP = 8'hff;

    // answer to an unmapped read
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // count clock sources
    typedef enum logic [1:0] {
        SRC_BUS,
        SRC_FIXED,
        SRC_EXT_RISE,
        SRC_EXT_FALL
    } mtm_src_e;

    localparam mtm_src_e SRC_RST = SRC_BUS;

endpackage

// *** rtl/mtm_prescaler.sv ***
`timescale 1ns/1ns
`default_nettype none

module mtm_prescaler (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // source ticks and control
    input  wire logic       tick_i,
    input  wire logic       clr_i,
    input  wire logic [2:0] sel_i,
    // divided tick
    output logic            tick_o
);

    typedef struct packed {
        logic [7:0] cnt;
    } mtm_pre_s;

    mtm_pre_s   s_q;
    mtm_pre_s   s_d;
    logic [7:0] term;

    // last count of the division period for the selected ratio
    always_comb begin
        if (sel_i == mtm_pkg::PS_SEL_TOP) begin
            term = mtm_pkg::PS_TERM_TOP;
        end else begin
            term = (8'h01 << sel_i) - 8'h01;
        end
    end

    // divide source ticks, a clear restarts the period
    // a count already past a newly chosen shorter period ends it at once
    always_comb begin
        s_d    = s_q;
        tick_o = 1'b0;
        if (clr_i) begin
            s_d.cnt = 8'h00;
        end else if (tick_i) begin
            if (s_q.cnt >= term) begin
                s_d.cnt = 8'h00;
                tick_o  = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    property p_div_one;
        (sel_i == 3'h0 && tick_i && !clr_i) |-> tick_o;
    endproperty
    a_div_one: assert property (p_div_one)
        else $error("divide by one missed a tick");

    property p_top_period;
        (tick_o && sel_i == mtm_pkg::PS_SEL_TOP) |-> (s_q.cnt == 8'hff) && tick_i;
    endproperty
    a_top_period: assert property (p_top_period)
        else $error("divide by 256 ticked early");

endmodule

`default_nettype wire

// *** rtl/mtm_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - count source: bus, fixed, external rise, fall
// - prescaler divides by 1..64 or 256
// - overflow at modulo, zero modulo means 0xff
// - wrap one count after reaching modulo
// - overflow flag sets as count becomes zero
// - enabled overflow flag raises the interrupt
// - firmware resets and stops the counter
// - count register reads the present count
module mtm_timer #(
    parameter int AW = 5
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          arst_n_i,
    // avalon-mm slave
    input  wire logic [AW-1:0] avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic      [31:0]   avs_readdata_o,
    output logic               avs_waitrequest_o,
    // count clock inputs
    input  wire logic          fixed_clk_i,
    input  wire logic          ext_ref_i,
    // interrupt
    output logic               irq_o
);

    typedef struct packed {
        logic [7:0]         cnt;
        logic [7:0]         modulo;
        mtm_pkg::mtm_src_e  src;
        logic [2:0]         ps;
        logic               overflow_flag;
        logic               overflow_irq_enable;
        logic               counter_halt_bit;
        logic               clr_armed;
        logic               irq_stat;
        logic               irq_mask;
        logic               fixed_prev;
        logic               ext_prev;
        logic               wreq;
        logic [31:0]        rdata;
        logic               irq;
    } mtm_state_s;

    mtm_state_s  s_q;
    mtm_state_s  s_d;

    logic [4:0]  addr;
    logic        req;
    logic        done;
    logic        wr_lane0;
    logic        rst_wr;
    logic        src_tick;
    logic        pre_in;
    logic        ptick;
    logic        ovf;
    logic [7:0]  limit;
    logic [31:0] rd_mux;

    // low address bits select the word, upper bits are ignored
    assign addr = avs_address_i[4:0];

    // a request completes in the cycle that waitrequest is low
    assign req  = avs_read_i | avs_write_i;
    assign done = req & ~s_q.wreq;

    // only the low byte lane carries register data
    assign wr_lane0 = done & avs_write_i & avs_byteenable_i[0];

    // counter reset request from a status and control write
    assign rst_wr = wr_lane0 && addr == mtm_pkg::OFS_STAT_CTRL
                    && avs_writedata_i[mtm_pkg::STC_RST_BIT];

    // overflow limit, zero modulo runs over the full range
    assign limit = (s_q.modulo == mtm_pkg::ZERO_MODULO)
                   ? mtm_pkg::FULL_RANGE : s_q.modulo;

    // pick the count clock and detect the chosen edge
    always_comb begin
        unique case (s_q.src)
            mtm_pkg::SRC_BUS:      src_tick = 1'b1;
            mtm_pkg::SRC_FIXED:    src_tick = fixed_clk_i & ~s_q.fixed_prev;
            mtm_pkg::SRC_EXT_RISE: src_tick = ext_ref_i & ~s_q.ext_prev;
            mtm_pkg::SRC_EXT_FALL: src_tick = ~ext_ref_i & s_q.ext_prev;
        endcase
    end

    // a halted timer feeds no ticks, so the prescaler also holds
    assign pre_in = src_tick & ~s_q.counter_halt_bit;

    mtm_prescaler u_prescaler (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .tick_i    (pre_in),
        .clr_i     (rst_wr),
        .sel_i     (s_q.ps),
        .tick_o    (ptick)
    );

    // read data multiplexer, unmapped words read as zero
    always_comb begin
        rd_mux = mtm_pkg::UNMAPPED_RD;
        unique case (addr)
            mtm_pkg::OFS_STAT_CTRL: begin
                rd_mux[mtm_pkg::STC_OVF_BIT]    = s_q.overflow_flag;
                rd_mux[mtm_pkg::STC_IRQ_EN_BIT] = s_q.overflow_irq_enable;
                rd_mux[mtm_pkg::STC_HALT_BIT]   = s_q.counter_halt_bit;
            end
            mtm_pkg::OFS_CLK_CFG: begin
                rd_mux[mtm_pkg::CFG_SRC_LSB +: 2] = s_q.src;
                rd_mux[mtm_pkg::CFG_PS_LSB +: 3]  = s_q.ps;
            end
            mtm_pkg::OFS_COUNT: begin
                rd_mux[7:0] = s_q.cnt;
            end
            mtm_pkg::OFS_MODULO: begin
                rd_mux[7:0] = s_q.modulo;
            end
            mtm_pkg::OFS_IRQ_STAT: begin
                rd_mux[mtm_pkg::IRQ_OVF_BIT] = s_q.irq_stat;
            end
            mtm_pkg::OFS_IRQ_MASK: begin
                rd_mux[mtm_pkg::IRQ_OVF_BIT] = s_q.irq_mask;
            end
            default: begin
                rd_mux = mtm_pkg::UNMAPPED_RD;
            end
        endcase
    end

    // next state: counting, bus handshake, register writes, flags
    always_comb begin
        s_d = s_q;
        ovf = 1'b0;

        // history for edge detection of the sampled clock inputs
        s_d.fixed_prev = fixed_clk_i;
        s_d.ext_prev   = ext_ref_i;

        // count on each prescaled tick, wrap one tick after the limit
        if (ptick) begin
            if (s_q.cnt == limit) begin
                s_d.cnt = 8'h00;
                ovf     = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end

        // one wait cycle per request, read data captured meanwhile
        if (req && s_q.wreq) begin
            s_d.wreq  = 1'b0;
            s_d.rdata = rd_mux;
        end else begin
            s_d.wreq  = 1'b1;
        end

        // reading the status with the flag set arms its clear
        if (done && avs_read_i && addr == mtm_pkg::OFS_STAT_CTRL
            && s_q.overflow_flag) begin
            s_d.clr_armed = 1'b1;
        end

        // register writes take effect at the completing edge
        if (wr_lane0) begin
            unique case (addr)
                mtm_pkg::OFS_STAT_CTRL: begin
                    s_d.overflow_irq_enable =
                        avs_writedata_i[mtm_pkg::STC_IRQ_EN_BIT];
                    s_d.counter_halt_bit =
                        avs_writedata_i[mtm_pkg::STC_HALT_BIT];
                    if (!avs_writedata_i[mtm_pkg::STC_OVF_BIT] && s_q.clr_armed) begin
                        s_d.overflow_flag = 1'b0;
                        s_d.clr_armed     = 1'b0;
                    end
                    if (avs_writedata_i[mtm_pkg::STC_RST_BIT]) begin
                        s_d.cnt           = mtm_pkg::COUNT_RST;
                        s_d.overflow_flag = 1'b0;
                        s_d.clr_armed     = 1'b0;
                    end
                end
                mtm_pkg::OFS_CLK_CFG: begin
                    s_d.src = mtm_pkg::mtm_src_e'(
                        avs_writedata_i[mtm_pkg::CFG_SRC_LSB +: 2]);
                    s_d.ps  = avs_writedata_i[mtm_pkg::CFG_PS_LSB +: 3];
                end
                mtm_pkg::OFS_MODULO: begin
                    s_d.modulo = avs_writedata_i[7:0];
                end
                mtm_pkg::OFS_IRQ_STAT: begin
                    if (avs_writedata_i[mtm_pkg::IRQ_OVF_BIT]) begin
                        s_d.irq_stat = 1'b0;
                    end
                end
                mtm_pkg::OFS_IRQ_MASK: begin
                    s_d.irq_mask = avs_writedata_i[mtm_pkg::IRQ_OVF_BIT];
                end
                default: begin
                    s_d.irq_mask = s_q.irq_mask;
                end
            endcase
        end

        // an overflow in the clearing cycle still sets the flags
        if (ovf) begin
            s_d.overflow_flag = 1'b1;
            s_d.irq_stat      = 1'b1;
        end

        // interrupt level from the flag enable and the sticky mask pair
        s_d.irq = (s_d.overflow_flag & s_d.overflow_irq_enable)
                  | (s_d.irq_stat & s_d.irq_mask);
    end

    // state register with reset values
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q                     <= '0;
            s_q.cnt                 <= mtm_pkg::COUNT_RST;
            s_q.modulo              <= mtm_pkg::MODULO_RST;
            s_q.src                 <= mtm_pkg::SRC_RST;
            s_q.ps                  <= mtm_pkg::PS_RST;
            s_q.overflow_irq_enable <= mtm_pkg::IRQ_EN_RST;
            s_q.counter_halt_bit    <= mtm_pkg::HALT_RST;
            s_q.wreq                <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign avs_readdata_o    = s_q.rdata;
    assign avs_waitrequest_o = s_q.wreq;
    assign irq_o             = s_q.irq;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    property p_bus_source;
        (s_q.src == mtm_pkg::SRC_BUS && !s_q.counter_halt_bit) |-> pre_in;
    endproperty
    a_bus_source: assert property (p_bus_source)
        else $error("bus clock source gave no tick");

    property p_rise_source;
        (s_q.src == mtm_pkg::SRC_EXT_RISE && pre_in) |->
            ext_ref_i && !$past(ext_ref_i);
    endproperty
    a_rise_source: assert property (p_rise_source)
        else $error("external rise tick without a rising edge");

    property p_step;
        (ptick && s_q.cnt != limit && !rst_wr) |=>
            s_q.cnt == $past(s_q.cnt) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not advance by one");

    property p_wrap;
        (ptick && s_q.cnt == limit && !rst_wr) |=>
            s_q.cnt == 8'h00 && s_q.overflow_flag && s_q.irq_stat;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap with overflow at the limit");

    property p_full_range;
        (s_q.modulo == 8'h00 && s_q.cnt == 8'hfe && ptick && !rst_wr) |=>
            s_q.cnt == 8'hff && !$rose(s_q.overflow_flag);
    endproperty
    a_full_range: assert property (p_full_range)
        else $error("zero modulo wrapped before the full range");

    property p_flag_at_zero;
        $rose(s_q.overflow_flag) |-> s_q.cnt == 8'h00;
    endproperty
    a_flag_at_zero: assert property (p_flag_at_zero)
        else $error("overflow flag rose with a nonzero count");

    property p_irq_level;
        (s_q.overflow_flag && s_q.overflow_irq_enable) |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled overflow flag without interrupt");

    property p_halt_hold;
        (s_q.counter_halt_bit && !rst_wr) |=> $stable(s_q.cnt);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halted counter moved");

    property p_reset_bit;
        rst_wr |=> s_q.cnt == 8'h00 && !s_q.overflow_flag;
    endproperty
    a_reset_bit: assert property (p_reset_bit)
        else $error("counter reset write did not clear");

    property p_flag_needs_read;
        (s_q.overflow_flag && !s_q.clr_armed && !rst_wr) |=> s_q.overflow_flag;
    endproperty
    a_flag_needs_read: assert property (p_flag_needs_read)
        else $error("overflow flag cleared without a prior read");

    property p_count_read;
        (avs_read_i && s_q.wreq && addr == mtm_pkg::OFS_COUNT) |=>
            avs_readdata_o == {24'h000000, $past(s_q.cnt)} && !avs_waitrequest_o;
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count read returned a stale value");

endmodule

`default_nettype wire

// *** dv/mtm_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic [4:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        fixed_clk_i;
    logic        ext_ref_i;
    logic        irq_o;
    int          fail_count;
    int          n_compared;

    mtm_timer #(.AW(5)) mtm_timer_inst (
        .clk_sys_i         (clk_sys_i),
        .arst_n_i          (arst_n_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .fixed_clk_i       (fixed_clk_i),
        .ext_ref_i         (ext_ref_i),
        .irq_o             (irq_o)
    );

    // 125 mhz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // closing report and verdict
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        @(posedge clk_sys_i);
        avs_address_i    <= a;
        avs_write_i      <= wr;
        avs_read_i       <= ~wr;
        avs_writedata_i  <= {24'h00_0000, wd};
        avs_byteenable_i <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (i == 20) begin
            fail_count++;
            $display("mismatch at %0t: bus handshake never completed", $time);
            summarize();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, 4'h1, rd);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [31:0] rd;
        bus(1'b0, a, 8'h00, 4'hf, rd);
        check(rd, {24'h00_0000, exp}, what);
    endtask

    // n rising edges on the fixed count clock
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            fixed_clk_i <= 1'b1;
            repeat (2) @(posedge clk_sys_i);
            fixed_clk_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
        end
    endtask

    task automatic ext_set(input logic v);
        @(posedge clk_sys_i);
        ext_ref_i <= v;
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_sys_i);
        check({31'h0, irq_o}, {31'h0, exp}, "irq level");
    endtask

    // reset values, read-back masks, ignored writes, unmapped places
    task automatic t_regs();
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'h10, "stat reset");
        rdchk(mtm_pkg::OFS_CLK_CFG, 8'h00, "cfg reset");
        rdchk(mtm_pkg::OFS_COUNT, 8'h00, "count reset");
        rdchk(mtm_pkg::OFS_MODULO, 8'h00, "modulo reset");
        rdchk(mtm_pkg::OFS_IRQ_STAT, 8'h00, "irq stat reset");
        rdchk(mtm_pkg::OFS_IRQ_MASK, 8'h00, "irq mask reset");
        wr(mtm_pkg::OFS_CLK_CFG, 8'hff);
        rdchk(mtm_pkg::OFS_CLK_CFG, 8'h37, "cfg mask");
        wr(mtm_pkg::OFS_MODULO, 8'ha5);
        rdchk(mtm_pkg::OFS_MODULO, 8'ha5, "modulo rw");
        begin
            logic [31:0] rd;
            bus(1'b1, mtm_pkg::OFS_MODULO, 8'h11, 4'h0, rd);
        end
        rdchk(mtm_pkg::OFS_MODULO, 8'ha5, "lane off write");
        wr(5'h18, 8'hff);
        rdchk(5'h18, 8'h00, "unmapped read");
        wr(mtm_pkg::OFS_IRQ_MASK, 8'hff);
        rdchk(mtm_pkg::OFS_IRQ_MASK, 8'h01, "mask rw");
        wr(mtm_pkg::OFS_IRQ_MASK, 8'h00);
        wr(mtm_pkg::OFS_MODULO, 8'h00);
        $display("test regs done");
    endtask

    // every prescale code divides fixed ticks by its ratio
    task automatic t_prescale();
        int dv;
        for (int c = 0; c < 8; c++) begin
            dv = (c == 7) ? 256 : (1 << c);
            wr(mtm_pkg::OFS_CLK_CFG, 8'h10 | 8'(c));
            wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
            pulse(dv - 1);
            rdchk(mtm_pkg::OFS_COUNT, 8'h00, "prescale below ratio");
            pulse(1);
            rdchk(mtm_pkg::OFS_COUNT, 8'h01, "prescale at ratio");
        end
        $display("test prescale done");
    endtask

    // external edges, halt and resume, bus clock source
    task automatic t_sources();
        logic [31:0] a;
        logic [31:0] b;
        ext_set(1'b0);
        wr(mtm_pkg::OFS_CLK_CFG, 8'h20);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
        ext_set(1'b1);
        ext_set(1'b0);
        ext_set(1'b1);
        rdchk(mtm_pkg::OFS_COUNT, 8'h02, "rising edges");
        wr(mtm_pkg::OFS_CLK_CFG, 8'h30);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
        ext_set(1'b0);
        ext_set(1'b1);
        rdchk(mtm_pkg::OFS_COUNT, 8'h01, "falling edges");
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h10);
        ext_set(1'b0);
        rdchk(mtm_pkg::OFS_COUNT, 8'h01, "halted");
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h00);
        ext_set(1'b1);
        ext_set(1'b0);
        rdchk(mtm_pkg::OFS_COUNT, 8'h02, "resumed");
        wr(mtm_pkg::OFS_CLK_CFG, 8'h00);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h10);
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00, 4'hf, a);
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00, 4'hf, b);
        check({31'h0, a == 32'h0}, 32'h0, "bus source counted");
        check(b, a, "bus source halted");
        $display("test sources done");
    endtask

    // modulo wrap, flag, both interrupt paths, flag clearing
    task automatic t_overflow();
        wr(mtm_pkg::OFS_CLK_CFG, 8'h10);
        wr(mtm_pkg::OFS_MODULO, 8'h03);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
        pulse(3);
        rdchk(mtm_pkg::OFS_COUNT, 8'h03, "at modulo");
        rdchk(mtm_pkg::OFS_IRQ_STAT, 8'h00, "no event yet");
        pulse(1);
        rdchk(mtm_pkg::OFS_COUNT, 8'h00, "wrapped");
        rdchk(mtm_pkg::OFS_IRQ_STAT, 8'h01, "event sticky");
        irq_chk(1'b0);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h40);
        irq_chk(1'b1);
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'hc0, "flag kept");
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h40);
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'h40, "flag cleared");
        irq_chk(1'b0);
        wr(mtm_pkg::OFS_IRQ_MASK, 8'h01);
        irq_chk(1'b1);
        wr(mtm_pkg::OFS_IRQ_STAT, 8'h01);
        irq_chk(1'b0);
        pulse(4);
        rdchk(mtm_pkg::OFS_COUNT, 8'h00, "second period");
        irq_chk(1'b1);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h60);
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'h40, "reset bit");
        wr(mtm_pkg::OFS_IRQ_STAT, 8'h01);
        irq_chk(1'b0);
        $display("test overflow done");
    endtask

    // zero modulo runs the full range
    task automatic t_full();
        wr(mtm_pkg::OFS_IRQ_MASK, 8'h00);
        wr(mtm_pkg::OFS_MODULO, 8'h00);
        wr(mtm_pkg::OFS_STAT_CTRL, 8'h20);
        pulse(255);
        rdchk(mtm_pkg::OFS_COUNT, 8'hff, "full range top");
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'h00, "no flag at top");
        pulse(1);
        rdchk(mtm_pkg::OFS_COUNT, 8'h00, "full range wrap");
        rdchk(mtm_pkg::OFS_STAT_CTRL, 8'h80, "flag at wrap");
        $display("test full range done");
    endtask

    // main sequence
    initial begin
        fail_count       = 0;
        n_compared       = 0;
        arst_n_i         = 1'b0;
        avs_address_i    = 5'h00;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h0000_0000;
        avs_byteenable_i = 4'h0;
        fixed_clk_i      = 1'b0;
        ext_ref_i        = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_prescale();
        t_sources();
        t_overflow();
        t_full();
        summarize();
    end
endmodule

`default_nettype wire
